//--- hw/sdb_chan_if.sv
// Carrier between the debouncer top and its per-channel qualifiers.
// Assumes all signals belong to the single clock domain of the top.
`timescale 1ns/1ps

interface sdb_chan_if #(
    parameter int N_CH = 8
);
    logic            tick;    // One-cycle sampling tick
    logic            bypass;  // Startup or undervoltage transparency
    logic [N_CH-1:0] raw;     // Switch inputs
    logic [N_CH-1:0] level;   // Registered debounced outputs
    wire  [N_CH-1:0] load;    // Per-channel load strobes, one driver per bit

    modport ctl  (output tick, output bypass, output raw, output level, input load);
    modport chan (input tick, input bypass, input raw, input level, output load);
endinterface // sdb_chan_if

//--- hw/sdb_debouncer.sv
// Multi-channel switch debouncer with optional change-of-state flag.
// Assumes inputs are synchronous to clk; the pin driver resolves the
// three-state outputs from filtered_switch_outputs_oe_n.
//
// Notes on behaviour
// [RULE_01] Output holds until input stable for 40ms.
// [RULE_02] Inputs sampled on ticks; consecutive samples qualify.
// [RULE_03] Mismatch or bounce clears channel counter.
// [RULE_04] Full qualification loads input into output.
// [RULE_05] Change flag falls with the output update.
// [RULE_06] Flag low on change, held until cleared.
// [RULE_07] Outputs driven only while enable low.
// [RULE_08] Asserting enable returns flag high.
// [RULE_09] Flag stays high while enable held low.
// [RULE_10] Host reads outputs after seeing low flag.
// [RULE_11] Undervoltage makes debouncer transparent.
// [RULE_12] Outputs start at the present input levels.
// [RULE_13] One, two or eight channels; flag eight only.
// [RULE_14] Unused enable is tied low by integrator.
`timescale 1ns/1ps

module sdb_debouncer #(
    parameter int N_CH        = sdb_pkg::DEFAULT_CHANNELS,
    parameter int TICK_CYCLES = sdb_pkg::SAMPLE_CYCLES,
    parameter int QUAL_TICKS  = sdb_pkg::QUAL_TICKS
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic [N_CH-1:0] raw_switch_inputs,
    input  wire logic            uvlo_active,
    input  wire logic            out_enable_n,
    output logic      [N_CH-1:0] filtered_switch_outputs,
    output logic                 filtered_switch_outputs_oe_n,
    output logic                 state_change_flag_n
);
    // ------------------------------------------------------------------
    // Build options
    // ------------------------------------------------------------------
    localparam bit HAS_CHANGE = (N_CH == sdb_pkg::CHANGE_CHANNELS); // [RULE_13]
    localparam int TW         = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    sdb_chan_if #(.N_CH(N_CH)) chan_bus ();

    sdb_pkg::sdb_state_t state_r;
    sdb_pkg::sdb_state_t state_nxt;
    logic [TW-1:0]       tick_cnt_r;
    logic [TW-1:0]       tick_cnt_nxt;
    logic                tick_r;
    logic                tick_nxt;
    logic [N_CH-1:0]     out_r;
    logic [N_CH-1:0]     out_nxt;
    logic                flag_n_r;
    logic                flag_n_nxt;
    logic                oe_n_r;
    logic                oe_n_nxt;
    logic                bypass;
    logic                change_evt;

    // ------------------------------------------------------------------
    // Startup sequencing
    // ------------------------------------------------------------------
    // Inputs cannot be loaded under async reset, so the first clocked
    // cycle after release copies them into the output register
    always_comb begin
        case (state_r)
            sdb_pkg::SDB_ST_INIT: state_nxt = sdb_pkg::SDB_ST_RUN;
            sdb_pkg::SDB_ST_RUN:  state_nxt = sdb_pkg::SDB_ST_RUN;
            default:              state_nxt = sdb_pkg::SDB_ST_INIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= sdb_pkg::SDB_ST_INIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Sampling oscillator
    // ------------------------------------------------------------------
    // Divider stands in for the on-chip oscillator; one tick per period
    always_comb begin
        tick_nxt     = 1'b0;
        tick_cnt_nxt = tick_cnt_r + TW'(1);
        if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_nxt = '0;
            tick_nxt     = 1'b1;                             // [RULE_02]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Channel qualifiers
    // ------------------------------------------------------------------
    assign bypass          = uvlo_active || (state_r == sdb_pkg::SDB_ST_INIT);
    assign chan_bus.tick   = tick_r;
    assign chan_bus.bypass = bypass;
    assign chan_bus.raw    = raw_switch_inputs;
    assign chan_bus.level  = out_r;

    generate
        for (genvar i = 0; i < N_CH; i++) begin : g_chan
            sdb_qualifier #(
                .CH         (i),
                .N_CH       (N_CH),
                .QUAL_TICKS (QUAL_TICKS)
            ) u_qual (
                .clk   (clk),
                .rst_n (rst_n),
                .bus   (chan_bus)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Debounced output register
    // ------------------------------------------------------------------
    // Transparent at startup and under undervoltage, else load on strobe
    always_comb begin
        out_nxt = out_r;
        if (state_r == sdb_pkg::SDB_ST_INIT) begin
            out_nxt = raw_switch_inputs;                     // [RULE_12]
        end else if (uvlo_active) begin
            out_nxt = raw_switch_inputs;                     // [RULE_11]
        end else begin
            for (int k = 0; k < N_CH; k++) begin
                if (chan_bus.load[k]) begin
                    out_nxt[k] = raw_switch_inputs[k];       // [RULE_01]
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Change flag and output enable
    // ------------------------------------------------------------------
    // Only qualified updates count; transparent passes raise no flag
    assign change_evt = !bypass && (|chan_bus.load);

    // Enable low dominates the flag, so a change seen while the host
    // is reading is not reported again afterwards
    always_comb begin
        flag_n_nxt = flag_n_r;
        oe_n_nxt   = 1'b0;                                   // [RULE_14]
        if (HAS_CHANGE) begin
            oe_n_nxt = out_enable_n;                         // [RULE_07]
            if (!out_enable_n) begin
                flag_n_nxt = 1'b1;                           // [RULE_08] [RULE_09]
            end else if (change_evt) begin
                flag_n_nxt = 1'b0;                           // [RULE_05] [RULE_06]
            end
        end else begin
            flag_n_nxt = 1'b1;                               // [RULE_13]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_n_r <= sdb_pkg::FLAG_RESET_N;
            oe_n_r   <= sdb_pkg::OE_RESET_N;
        end else begin
            flag_n_r <= flag_n_nxt;
            oe_n_r   <= oe_n_nxt;
        end
    end

    assign filtered_switch_outputs      = out_r;
    assign filtered_switch_outputs_oe_n = oe_n_r;
    assign state_change_flag_n          = flag_n_r;

endmodule // sdb_debouncer

//--- hw/sdb_pkg.sv
// Constants and types shared by the switch debouncer modules.
// Assumes a single 100 MHz system clock drives the whole block.
package sdb_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int QUAL_TIME_MS     = 40;
    localparam int SAMPLE_PERIOD_US = 1000;
    // Cycles between two sampling ticks of the internal oscillator
    localparam int SAMPLE_CYCLES    = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
    // Consecutive stable samples that make up the qualification period
    localparam int QUAL_TICKS       = (QUAL_TIME_MS * 1000) / SAMPLE_PERIOD_US;

    // ------------------------------------------------------------------
    // Variants
    // ------------------------------------------------------------------
    localparam int DEFAULT_CHANNELS = 8;
    localparam int CHANGE_CHANNELS  = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic FLAG_RESET_N   = 1'b1;
    localparam logic OE_RESET_N     = 1'b1;

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        SDB_ST_INIT = 1'b0,
        SDB_ST_RUN  = 1'b1
    } sdb_state_t;

endpackage

//--- hw/sdb_qualifier.sv
// Qualification counter for one debouncer channel.
// Assumes tick is a one-cycle pulse and level is the registered output.
`timescale 1ns/1ps

module sdb_qualifier #(
    parameter int CH         = 0,
    parameter int N_CH       = 8,
    parameter int QUAL_TICKS = sdb_pkg::QUAL_TICKS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sdb_chan_if.chan  bus
);
    localparam int             CW   = $clog2(QUAL_TICKS + 1);
    localparam logic [CW-1:0]  LAST = CW'(QUAL_TICKS - 1);

    logic          prev_r;
    logic          prev_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          differs;
    logic          stable;

    // ------------------------------------------------------------------
    // Sample comparison and counter
    // ------------------------------------------------------------------
    // Differs is the inverted XNOR of input against output
    assign differs = bus.raw[CH] != bus.level[CH];
    assign stable  = bus.raw[CH] == prev_r;

    // Count only while a new level persists; a bounce restarts the count
    always_comb begin
        prev_nxt = prev_r;
        cnt_nxt  = cnt_r;
        if (bus.bypass) begin
            prev_nxt = bus.raw[CH];
            cnt_nxt  = '0;
        end else if (bus.tick) begin
            prev_nxt = bus.raw[CH];                          // [RULE_02]
            if (!differs || !stable) begin
                cnt_nxt = '0;                                // [RULE_03]
            end else if (cnt_r == LAST) begin
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + CW'(1);                    // [RULE_02]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            cnt_r  <= '0;
        end else begin
            prev_r <= prev_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // Strobe on the tick that completes the qualification period
    assign bus.load[CH] = bus.tick && !bus.bypass && differs && stable
                          && (cnt_r == LAST);                // [RULE_04]

endmodule // sdb_qualifier

//--- verification/sdb_debouncer_sva.sv
// Port-level checker for the switch debouncer, eight-channel build.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module sdb_debouncer_sva #(
    parameter int N_CH        = 8,
    parameter int TICK_CYCLES = 4,
    parameter int QUAL_TICKS  = 3
) (
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic [N_CH-1:0] raw_switch_inputs,
    input wire logic            uvlo_active,
    input wire logic            out_enable_n,
    input wire logic [N_CH-1:0] filtered_switch_outputs,
    input wire logic            filtered_switch_outputs_oe_n,
    input wire logic            state_change_flag_n
);
    // Worst settle time plus margin for tick phase jitter
    localparam int LIM = (QUAL_TICKS + 2) * TICK_CYCLES + 4;
    logic [N_CH-1:0] raw_q_r;
    int              stab_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Counts cycles the inputs held still; saturates so it never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_q_r <= '0;
            stab_r  <= 0;
        end else begin
            raw_q_r <= raw_switch_inputs;
            stab_r  <= (raw_switch_inputs != raw_q_r) ? 0
                       : (stab_r > LIM ? stab_r : stab_r + 1);
        end
    end
    a_flag_clear_en: assert property (!out_enable_n |=> state_change_flag_n)
        else $error("flag not cleared by enable");
    a_flag_high_en: assert property (!out_enable_n [*2] |-> state_change_flag_n)
        else $error("flag low while enabled");
    a_flag_hold: assert property (!state_change_flag_n && out_enable_n |=> !state_change_flag_n)
        else $error("flag released without enable");
    a_flag_with_load: assert property ($fell(state_change_flag_n) |->
        filtered_switch_outputs != $past(filtered_switch_outputs))
        else $error("flag fell without output update");
    a_flag_no_uvlo: assert property ($fell(state_change_flag_n) |-> !$past(uvlo_active))
        else $error("transparent update set the flag");
    a_oe_follow: assert property (1'b1 |=>
        filtered_switch_outputs_oe_n == $past(out_enable_n))
        else $error("output enable not followed");
    a_uvlo_pass: assert property (uvlo_active |=>
        filtered_switch_outputs == $past(raw_switch_inputs))
        else $error("undervoltage not transparent");
    a_change_cause: assert property (!$past(uvlo_active) |->
        ((filtered_switch_outputs ^ $past(filtered_switch_outputs))
         & (filtered_switch_outputs ^ $past(raw_switch_inputs))) == '0)
        else $error("output moved away from input");
    a_settle_bound: assert property (stab_r == LIM && !uvlo_active |->
        filtered_switch_outputs == raw_switch_inputs)
        else $error("stable input not loaded in time");
    c_flag: cover property ($fell(state_change_flag_n));
    c_uvlo: cover property (uvlo_active ##1 uvlo_active);
    c_read: cover property (!out_enable_n ##1 !filtered_switch_outputs_oe_n);
endmodule // sdb_debouncer_sva

bind sdb_debouncer sdb_debouncer_sva #(.N_CH(N_CH), .TICK_CYCLES(TICK_CYCLES),
    .QUAL_TICKS(QUAL_TICKS)) u_sva (.clk(clk), .rst_n(rst_n),
    .raw_switch_inputs(raw_switch_inputs), .uvlo_active(uvlo_active),
    .out_enable_n(out_enable_n), .filtered_switch_outputs(filtered_switch_outputs),
    .filtered_switch_outputs_oe_n(filtered_switch_outputs_oe_n),
    .state_change_flag_n(state_change_flag_n));

//--- verification/sdb_host_model.sv
// Polling host on the debouncer data bus.
// Assumes the bus already resolves the three-state outputs.
`timescale 1ns/1ps
module sdb_host_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       poll_en,
    input  wire logic       hold_en,
    input  wire logic       flag_n,
    input  wire logic [7:0] data_bus,
    output logic            en_n,
    output logic      [7:0] read_data,
    output int              read_cnt
);
    int step;
    // Sees a low flag, enables, reads one cycle after the bus turns on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_n <= 1'b1;
            step <= 0;
            read_cnt <= 0;
        end else if (hold_en) begin
            en_n <= 1'b0;
        end else if (step == 0) begin
            en_n <= !(poll_en && !flag_n);
            step <= (poll_en && !flag_n) ? 1 : 0;
        end else if (step == 2) begin
            read_data <= data_bus;
            read_cnt <= read_cnt + 1;
            en_n <= 1'b1;
            step <= 0;
        end else begin
            step <= step + 1;
        end
    end
endmodule // sdb_host_model

//--- verification/tb.sv
// Self-checking bench for the eight-channel debouncer with a polling host.
// Assumes short tick and qualification parameters to keep the run brief.
`timescale 1ns/1ps
module tb;
    localparam int TC = 4;
    localparam int QT = 3;
    localparam int LAT = (QT + 2) * TC;
    logic clk = 0, rst_n = 0, uvlo = 0, poll_en = 0, hold_en = 0, en_n, oe_n, flag_n;
    logic [7:0] raw = 8'h00, outs, rd, v, prev;
    int   bad_count = 0, tests_run = 0, rc, exp_q[$];
    // Undriven bus shows the inverse so a stale read cannot match
    wire [7:0] bus = oe_n ? ~outs : outs;
    always #5 clk = ~clk;
    sdb_debouncer #(.N_CH(8), .TICK_CYCLES(TC), .QUAL_TICKS(QT)) dut (.clk(clk), .rst_n(rst_n),
        .raw_switch_inputs(raw), .uvlo_active(uvlo), .out_enable_n(en_n),
        .filtered_switch_outputs(outs), .filtered_switch_outputs_oe_n(oe_n),
        .state_change_flag_n(flag_n));
    sdb_host_model host (.clk(clk), .rst_n(rst_n), .poll_en(poll_en), .hold_en(hold_en),
        .flag_n(flag_n), .data_bus(bus), .en_n(en_n), .read_data(rd), .read_cnt(rc));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog sized well past the whole sequence
    initial begin
        #100us;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        void'($urandom(91));
        raw = $urandom;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_n(2);
        chk8(outs, raw, "startup level");
        chk8({7'h0, flag_n}, 8'h01, "startup flag");
        $display("test startup done");
        for (int i = 0; i < 3; i++) begin
            prev = outs;
            v = raw ^ 8'($urandom_range(1, 255));
            @(posedge clk) raw <= v;
            wait_n(QT * TC);
            chk8(outs, prev, "held early");
            wait_n(LAT);
            chk8(outs, v, "qualified load");
            chk8({7'h0, flag_n}, 8'h00, "flag set");
            @(posedge clk) hold_en <= 1'b1;
            @(posedge clk) hold_en <= 1'b0;
            wait_n(2);
            chk8({7'h0, flag_n}, 8'h01, "flag cleared");
        end
        $display("test qualify done");
        prev = outs;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) raw <= raw ^ 8'h01;
            wait_n(5);
            chk8(outs, prev, "bounce ignored");
        end
        $display("test bounce done");
        @(posedge clk) poll_en <= 1'b1;
        v = raw ^ 8'h5a;
        exp_q.push_back(v);
        @(posedge clk) raw <= v;
        wait_n(LAT + QT * TC + 6);
        chk8(8'(rc), 8'h01, "host read count");
        chk8(rd, 8'(exp_q.pop_front()), "host read data");
        chk8({7'h0, flag_n}, 8'h01, "flag after read");
        @(posedge clk) poll_en <= 1'b0;
        $display("test host read done");
        @(posedge clk) hold_en <= 1'b1;
        v = raw ^ 8'ha5;
        @(posedge clk) raw <= v;
        wait_n(LAT + QT * TC);
        chk8(outs, v, "update while enabled");
        chk8({6'h0, oe_n, flag_n}, 8'h01, "driven and unflagged");
        @(posedge clk) hold_en <= 1'b0;
        wait_n(3);
        chk8({7'h0, oe_n}, 8'h01, "three-state again");
        $display("test enable hold done");
        @(posedge clk) uvlo <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            @(posedge clk) raw <= v;
            wait_n(1);
            chk8(outs, v, "transparent");
        end
        chk8({7'h0, flag_n}, 8'h01, "no flag in lockout");
        @(posedge clk) uvlo <= 1'b0;
        $display("test lockout done");
        print_verdict();
    end
endmodule // tb
